// *** hw/channel_protect_latch_ctrl.sv ***
// Channel protection, pairing, inrush restart and PWM generators
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module channel_protect_latch_ctrl #(
  parameter int BIM_TIMEOUT_CYC = chan_prot_pkg::BIM_TIMEOUT_CYC,  // Inrush mode timeout
  parameter int INRUSH_CYC      = chan_prot_pkg::INRUSH_CYC        // Restart delay
) (
  input  wire logic                               clk_sys_i,   // System clock
  input  wire logic                               rst_i,       // Async reset
  input  wire logic [chan_prot_pkg::ADDR_W-1:0]   addr_i,      // Register address
  input  wire logic [chan_prot_pkg::DATA_W-1:0]   wdata_i,     // Write data
  input  wire logic                               wr_i,        // Write strobe
  input  wire logic                               rd_i,        // Read strobe
  output var  logic [chan_prot_pkg::DATA_W-1:0]   rdata_o,     // Read data
  input  wire logic [chan_prot_pkg::CH_N-1:0]     ovl_i,       // Overload detect
  input  wire logic [chan_prot_pkg::CH_N-1:0]     otemp_i,     // Over-temperature
  input  wire logic [chan_prot_pkg::CH_N-1:0]     inv_i,       // Inverse current
  output var  logic [chan_prot_pkg::CH_N-1:0]     gate_en_o,   // Power stage enables
  output var  logic [chan_prot_pkg::GEN_N-1:0]    pwm_o        // Generator outputs
);
  import chan_prot_pkg::*;

  localparam logic [CW-1:0] BIM_LAST = CW'(BIM_TIMEOUT_CYC - 1);  // Timeout end
  localparam logic [CW-1:0] RST_LAST = CW'(INRUSH_CYC - 1);       // Restart end

  // ==========================================================
  // Input synchronisers
  logic [3*CH_N-1:0] sy1_r, sy2_r;        // Two-stage sync
  logic [CH_N-1:0]   ovl_s, ot_s, inv_s;  // Synchronised levels
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= {inv_i, otemp_i, ovl_i};
      sy2_r <= sy1_r;
    end
  end
  assign {inv_s, ot_s, ovl_s} = sy2_r;

  // ==========================================================
  // Register file
  logic [CH_N-1:0]   cmd_r, cmd_nxt;     // Channel commands
  logic [PAIR_N-1:0] pair_r, pair_nxt;   // pair_sync_bits
  logic [CH_N-1:0]   bim_r, bim_nxt;     // inrush_mode_bit
  logic [CH_N-1:0]   err_r, err_nxt;     // channel_error_flag
  pwm_cfg_s          cfg_r [GEN_N];      // Written PWM configs
  pwm_cfg_s          cfg_nxt [GEN_N];
  logic [2*CH_N-1:0] map_r, map_nxt;     // Generator maps
  logic [3:0]        trim_r, trim_nxt;   // base_freq_trim
  logic [DATA_W-1:0] rdata_nxt;          // Read mux
  logic [CH_N-1:0]   clr_w;              // Latch clear pulses
  logic [CH_N-1:0]   bim_clr, err_set;   // From channel logic
  logic [CH_N-1:0]   gate_r;             // Gate enables

  // Decode writes and compute read data
  always_comb begin
    cmd_nxt  = cmd_r;
    pair_nxt = pair_r;
    map_nxt  = map_r;
    trim_nxt = trim_r;
    cfg_nxt  = cfg_r;
    clr_w    = '0;
    bim_nxt  = bim_r & ~bim_clr;
    if (wr_i) begin
      unique case (addr_i)
        A_CMD:   cmd_nxt  = wdata_i[CH_N-1:0];
        A_PAIR:  pair_nxt = wdata_i[PAIR_N-1:0];
        A_CLR:   clr_w    = wdata_i[CH_N-1:0];
        A_BIM:   bim_nxt  = wdata_i[CH_N-1:0];
        A_PWM0:  cfg_nxt[0] = wdata_i[FREQ_LSB+1:DUTY_LSB];
        A_PWM1:  cfg_nxt[1] = wdata_i[FREQ_LSB+1:DUTY_LSB];
        A_MAP:   map_nxt  = wdata_i;
        A_TRIM:  trim_nxt = wdata_i[3:0];
        default: ;                                // Unmapped or read only
      endcase
    end
    // Hardware set wins over the clear
    err_nxt   = (err_r & ~clr_w) | err_set;
    rdata_nxt = '0;
    if (rd_i) begin
      unique case (addr_i)
        A_CMD:   rdata_nxt = DATA_W'(cmd_r);
        A_PAIR:  rdata_nxt = DATA_W'(pair_r);
        A_BIM:   rdata_nxt = DATA_W'(bim_r);
        A_ERR:   rdata_nxt = DATA_W'(err_r);
        A_PWM0:  rdata_nxt = DATA_W'(cfg_r[0]);
        A_PWM1:  rdata_nxt = DATA_W'(cfg_r[1]);
        A_MAP:   rdata_nxt = map_r;
        A_TRIM:  rdata_nxt = DATA_W'(trim_r);
        A_GATE:  rdata_nxt = DATA_W'(gate_r);
        default: rdata_nxt = '0;                  // Clear reg and unmapped
      endcase
    end
  end

  // Register the register file
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_r   <= '0;
      pair_r  <= '0;
      bim_r   <= '0;
      err_r   <= '0;
      cfg_r   <= '{default: '0};
      map_r   <= '0;
      trim_r  <= TRIM_NOM;
      rdata_o <= '0;
    end else begin
      cmd_r   <= cmd_nxt;
      pair_r  <= pair_nxt;
      bim_r   <= bim_nxt;
      err_r   <= err_nxt;
      cfg_r   <= cfg_nxt;
      map_r   <= map_nxt;
      trim_r  <= trim_nxt;
      rdata_o <= rdata_nxt;
    end
  end

  // ==========================================================
  // Base frequency divider with trim
  logic [11:0] div_r, div_nxt;   // Divider count
  logic [11:0] div_last;         // Trimmed terminal count
  logic        tick_r, tick_nxt; // Base frequency enable
  always_comb begin
    if (trim_r == TRIM_RSVD) begin  // Reserved code runs nominal
      div_last = 12'(F_INT_DIV - 1);
    end else begin  // Higher code shortens the period
      div_last = 12'(F_INT_DIV - 1 - (int'(trim_r) - int'(TRIM_NOM)) * TRIM_STEP);
    end
    tick_nxt = (div_r >= div_last);
    div_nxt  = tick_nxt ? '0 : div_r + 12'h001;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ==========================================================
  // PWM generators
  logic [GEN_N-1:0] pwm_r;  // Generator levels
  genvar gi;
  for (gi = 0; gi < GEN_N; gi++) begin : g_pwm
    logic [9:0] cnt_r, cnt_nxt;   // Period counter
    pwm_cfg_s   act_r, act_nxt;   // Config in force this period
    logic       out_nxt;          // Next level
    logic [9:0] last;             // Period end
    logic [7:0] pos;              // Scaled position
    logic       wrap;             // Period boundary
    always_comb begin
      unique case (act_r.freq)
        FQ_1024: begin
          last = 10'h3FF;
          pos  = cnt_r[9:2];
        end
        FQ_512: begin
          last = 10'h1FF;
          pos  = cnt_r[8:1];
        end
        default: begin
          last = 10'h0FF;
          pos  = cnt_r[7:0];
        end
      endcase
      wrap    = tick_r && (cnt_r >= last);
      cnt_nxt = tick_r ? (wrap ? '0 : cnt_r + 10'h001) : cnt_r;
      act_nxt = wrap ? cfg_r[gi] : act_r;
      out_nxt = (act_r.freq == FQ_FULL) || (pos < act_r.duty);
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_r     <= '0;
        act_r     <= '0;
        pwm_r[gi] <= 1'b0;
      end else begin
        cnt_r     <= cnt_nxt;
        act_r     <= act_nxt;
        pwm_r[gi] <= out_nxt;
      end
    end
    duty_hold_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !wrap |=> $stable(act_r)) else $error("duty changed inside a period");
    full_on_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      act_r.freq == FQ_FULL |=> pwm_r[gi]) else $error("code 3 not constant on");
    pwm_wrap_c : cover property (@(posedge clk_sys_i) disable iff (rst_i) wrap);
  end
  assign pwm_o = pwm_r;

  // ==========================================================
  // Per-channel protection
  logic [CH_N-1:0] req;    // Commanded on level
  logic [CH_N-1:0] fault;  // Own fault while on
  genvar ci;
  for (ci = 0; ci < CH_N; ci++) begin : g_ch
    localparam int P = ci ^ 2;                  // Partner channel
    localparam int B = (ci / 4) * 2 + (ci % 2); // Pairing bit
    ch_state_e       st_r, st_nxt;            // Latch state
    logic [CW-1:0]   rcnt_r, rcnt_nxt;        // Restart counter
    logic [CW-1:0]   tcnt_r, tcnt_nxt;        // Inrush timer
    logic            req_q_r;                 // Previous request
    logic            trig;                    // Shutdown trigger
    // PWM mapping gates the command
    assign req[ci]   = cmd_r[ci] & (~map_r[ci] | pwm_r[0])
                     & (~map_r[MAP1_LSB+ci] | pwm_r[1]);
    assign fault[ci] = gate_r[ci] & ~inv_s[ci] & (ovl_s[ci] | ot_s[ci]);
    always_comb begin
      trig = fault[ci] | (pair_r[B] & fault[P] & gate_r[ci] & ~inv_s[ci]);
      st_nxt   = st_r;
      rcnt_nxt = rcnt_r;
      unique case (st_r)
        CH_RUN: begin
          if (trig) begin
            st_nxt   = bim_r[ci] ? CH_RESTART : CH_LATCHED;
            rcnt_nxt = '0;
          end
        end
        CH_LATCHED: begin  // Held until host clears
          if (clr_w[ci]) st_nxt = CH_RUN;
        end
        CH_RESTART: begin  // Counting the restart delay
          rcnt_nxt = rcnt_r + CW'(1);
          if (rcnt_r >= RST_LAST) st_nxt = CH_RUN;
        end
      endcase
      // Inverse current on a hot channel still flags it
      err_set[ci] = trig | (inv_s[ci] & gate_r[ci] & ot_s[ci]);
      // Timer restarts on switch-on and runs while mode is set
      if (req[ci] && !req_q_r) tcnt_nxt = '0;
      else if (bim_r[ci] && tcnt_r < BIM_LAST) tcnt_nxt = tcnt_r + CW'(1);
      else tcnt_nxt = tcnt_r;
      bim_clr[ci] = (req_q_r && !req[ci])
                  || (bim_r[ci] && tcnt_r >= BIM_LAST);
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        st_r       <= CH_RUN;
        rcnt_r     <= '0;
        tcnt_r     <= '0;
        req_q_r    <= 1'b0;
        gate_r[ci] <= 1'b0;
      end else begin
        st_r       <= st_nxt;
        rcnt_r     <= rcnt_nxt;
        tcnt_r     <= tcnt_nxt;
        req_q_r    <= req[ci];
        gate_r[ci] <= req[ci] && (st_nxt == CH_RUN);
      end
    end
    pair_trip_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      pair_r[B] && fault[P] && gate_r[ci] && !inv_s[ci] |=> !gate_r[ci])
      else $error("partner fault did not switch channel off");
    unpaired_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !pair_r[B] && !fault[ci] && st_r == CH_RUN |=> st_r == CH_RUN)
      else $error("unpaired channel tripped");
    latch_hold_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      st_r == CH_LATCHED && !clr_w[ci] |=> st_r == CH_LATCHED && !gate_r[ci])
      else $error("latch released without clear");
    auto_restart_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      st_r == CH_RESTART && rcnt_r >= RST_LAST |=> st_r == CH_RUN)
      else $error("inrush restart missed");
    timer_start_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      req[ci] && !req_q_r |=> tcnt_r == '0) else $error("inrush timer not restarted");
    off_clears_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      req_q_r && !req[ci] && !(wr_i && addr_i == A_BIM) |=> !bim_r[ci])
      else $error("switch-off kept inrush mode");
    no_latch_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      st_r == CH_RUN && trig && bim_r[ci] |=> st_r == CH_RESTART && err_r[ci])
      else $error("inrush mode latched channel");
    bim_expire_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      bim_r[ci] && tcnt_r >= BIM_LAST && !(wr_i && addr_i == A_BIM) |=> !bim_r[ci])
      else $error("inrush mode not timed out");
    inv_keep_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
      inv_s[ci] && st_r == CH_RUN && req[ci] |=> gate_r[ci])
      else $error("inverse current switched channel");
    latched_c : cover property (@(posedge clk_sys_i) disable iff (rst_i)
      st_r == CH_LATCHED ##1 st_r == CH_RUN);
    restart_c : cover property (@(posedge clk_sys_i) disable iff (rst_i)
      st_r == CH_RESTART ##1 st_r == CH_RUN);
    pair_c : cover property (@(posedge clk_sys_i) disable iff (rst_i)
      pair_r[B] && fault[P] && !fault[ci] && gate_r[ci]);
  end
  assign gate_en_o = gate_r;

endmodule : channel_protect_latch_ctrl
`default_nettype wire

// *** shared/chan_prot_pkg.sv ***
// Package: constants, types and register map of the channel protection block
package chan_prot_pkg;
  // ==========================================================
  // Sizes
  localparam int CH_N   = 8;            // Channels
  localparam int PAIR_N = 4;            // Pairing bits
  localparam int GEN_N  = 2;            // PWM generators
  localparam int ADDR_W = 4;            // Register address width
  localparam int DATA_W = 16;           // Register data width
  localparam int CW     = 22;           // Per-channel timer width
  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] A_CMD   = 4'h0;  // Channel on/off commands
  localparam logic [ADDR_W-1:0] A_PAIR  = 4'h1;  // pair_sync_bits
  localparam logic [ADDR_W-1:0] A_CLR   = 4'h2;  // latch_clear_reg, write 1 to clear
  localparam logic [ADDR_W-1:0] A_BIM   = 4'h3;  // inrush_mode_bit per channel
  localparam logic [ADDR_W-1:0] A_ERR   = 4'h4;  // channel_error_flag, read only
  localparam logic [ADDR_W-1:0] A_PWM0  = 4'h5;  // Generator 0 config
  localparam logic [ADDR_W-1:0] A_PWM1  = 4'h6;  // Generator 1 config
  localparam logic [ADDR_W-1:0] A_MAP   = 4'h7;  // [7:0] gen 0 map, [15:8] gen 1 map
  localparam logic [ADDR_W-1:0] A_TRIM  = 4'h8;  // base_freq_trim
  localparam logic [ADDR_W-1:0] A_GATE  = 4'h9;  // Gate enable status, read only
  // ==========================================================
  // Field positions and reset values
  localparam int DUTY_LSB = 0;          // duty_cycle_field position
  localparam int FREQ_LSB = 8;          // period_divider_field position
  localparam int MAP1_LSB = 8;          // Generator 1 map position
  localparam logic [3:0] TRIM_NOM  = 4'h8;   // Nominal trim code, reset value
  localparam logic [3:0] TRIM_RSVD = 4'h0;   // Reserved trim code
  // ==========================================================
  // Timing
  localparam int CLK_HZ          = 100_000_000;  // System clock
  localparam int F_INT_HZ        = 102_400;      // Nominal base frequency
  localparam int F_INT_DIV       = CLK_HZ / F_INT_HZ;  // Cycles per base tick
  localparam int TRIM_STEP       = 35;           // Cycles per trim step
  localparam int BIM_TIMEOUT_MS  = 40;           // inrush_mode_timeout
  localparam int BIM_TIMEOUT_CYC = BIM_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int INRUSH_US       = 200;          // Inrush restart delay
  localparam int INRUSH_CYC      = INRUSH_US * (CLK_HZ / 1_000_000);
  // ==========================================================
  // PWM period codes
  localparam logic [1:0] FQ_1024 = 2'h0;  // Base / 1024
  localparam logic [1:0] FQ_512  = 2'h1;  // Base / 512
  localparam logic [1:0] FQ_256  = 2'h2;  // Base / 256
  localparam logic [1:0] FQ_FULL = 2'h3;  // Constant on
  // ==========================================================
  // Types
  typedef struct packed {
    logic [1:0] freq;   // period_divider_field
    logic [7:0] duty;   // duty_cycle_field
  } pwm_cfg_s;
  typedef enum logic [1:0] {CH_RUN, CH_LATCHED, CH_RESTART} ch_state_e;
endpackage : chan_prot_pkg

// *** sim/load_model.sv ***
// Load-side model: switched loads that report overload, heat and inverse current
`timescale 1ns/1ps
`default_nettype none
module load_model (
  input  wire logic [chan_prot_pkg::CH_N-1:0] gate_en_i,  // Power stage enables
  input  wire logic [chan_prot_pkg::CH_N-1:0] short_i,    // Shorted load request
  input  wire logic [chan_prot_pkg::CH_N-1:0] hot_i,      // Hot load request
  input  wire logic [chan_prot_pkg::CH_N-1:0] rev_i,      // Back-fed load request
  output var  logic [chan_prot_pkg::CH_N-1:0] ovl_o,      // Overload detect
  output var  logic [chan_prot_pkg::CH_N-1:0] otemp_o,    // Over-temperature
  output var  logic [chan_prot_pkg::CH_N-1:0] inv_o       // Inverse current
);
  import chan_prot_pkg::*;
  // ==========================================================
  // Load behaviour
  // A shorted or hot load only draws current while its switch is on
  always_comb begin
    ovl_o   = short_i & gate_en_i;
    otemp_o = hot_i & gate_en_i;
    inv_o   = rev_i;  // Back-feeding happens whatever the switch does
  end
endmodule : load_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench of the channel protection block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import chan_prot_pkg::*;
  // ==========================================================
  // Signals
  logic              clk_sys_i = 1'b0;  // System clock
  logic              rst_i     = 1'b1;  // Reset
  logic [3:0]        addr_i    = '0;    // Register address
  logic [15:0]       wdata_i   = '0;    // Write data
  logic              wr_i      = 1'b0;  // Write strobe
  logic              rd_i      = 1'b0;  // Read strobe
  logic [15:0]       rdata_o;           // Read data
  logic [7:0]        ovl_i, otemp_i, inv_i, gate_en_o;
  logic [1:0]        pwm_o;             // Generator outputs
  logic [7:0]        short_r = '0;      // Shorted loads
  logic [7:0]        hot_r   = '0;      // Hot loads
  logic [7:0]        rev_r   = '0;      // Back-fed loads
  logic [15:0]       rd_v;              // Last read value
  int                mismatches      = 0;
  int                samples_checked = 0;
  int                cyc_cnt         = 0;
  int                lo;
  // ==========================================================
  // Clock, timeout
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // ==========================================================
  // Design and loads
  channel_protect_latch_ctrl #(.BIM_TIMEOUT_CYC(200), .INRUSH_CYC(20)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ovl_i(ovl_i), .otemp_i(otemp_i),
    .inv_i(inv_i), .gate_en_o(gate_en_o), .pwm_o(pwm_o));
  load_model load_u (.gate_en_i(gate_en_o), .short_i(short_r), .hot_i(hot_r),
    .rev_i(rev_r), .ovl_o(ovl_i), .otemp_o(otemp_i), .inv_o(inv_i));
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask : wr_reg
  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd_reg
  // Wait some cycles, then compare the gate enables
  task automatic gate_is(input int n, input logic [7:0] exp);
    repeat (n) @(posedge clk_sys_i);
    #1 check("gate_en", {8'h00, gate_en_o}, {8'h00, exp});
  endtask : gate_is
  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Register rows: address, write data, read-back value
  localparam int ROWS = 17;
  logic [3:0]  ra [ROWS] = '{A_PAIR, A_PAIR, A_CLR, A_ERR, A_PWM0, A_PWM1, A_PWM0, A_PWM1,
                             A_MAP, A_MAP, A_TRIM, A_TRIM, 4'hF, 4'hA, A_CMD, A_GATE, A_CMD};
  logic [15:0] rw [ROWS] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h1234,
                             16'h0000, 16'h0000, 16'h1234, 16'h0000, 16'hFFFF, 16'h0008,
                             16'hFFFF, 16'hFFFF, 16'h00A5, 16'h0000, 16'h00FF};
  logic [15:0] re [ROWS] = '{16'h000F, 16'h0000, 16'h0000, 16'h0000, 16'h03FF, 16'h0234,
                             16'h0000, 16'h0000, 16'h1234, 16'h0000, 16'h000F, 16'h0008,
                             16'h0000, 16'h0000, 16'h00A5, 16'h00A5, 16'h00FF};
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    gate_is(1, 8'h00);
    rd_reg(A_TRIM, rd_v);
    check("trim reset", rd_v, 16'h0008);
    for (int i = 0; i < ROWS; i++) begin
      wr_reg(ra[i], rw[i]);
      rd_reg(ra[i], rd_v);
      check("register row", rd_v, re[i]);
    end
    // A new config waits for the running period to end, so the output stays low
    wr_reg(A_PWM0, 16'h03FF);
    repeat (3) @(posedge clk_sys_i);
    #1 check("pwm hold", {14'h0000, pwm_o}, 16'h0000);
    // Each pair: a fault on the lower channel takes both down until cleared
    for (int p = 0; p < 4; p++) begin
      lo = (p < 2) ? p : p + 2;
      wr_reg(A_PAIR, 16'(1 << p));
      short_r[lo] <= 1'b1;
      gate_is(4, 8'hFF & ~(8'(1 << lo) | 8'(4 << lo)));
      short_r[lo] <= 1'b0;
      gate_is(10, 8'hFF & ~(8'(1 << lo) | 8'(4 << lo)));
      rd_reg(A_ERR, rd_v);
      check("err flag", rd_v & 16'(1 << lo), 16'(1 << lo));
      wr_reg(A_CLR, 16'h00FF);
      gate_is(3, 8'hFF);
      // A fault on the upper channel takes the lower one down as well
      short_r[lo+2] <= 1'b1;
      gate_is(4, 8'hFF & ~(8'(1 << lo) | 8'(4 << lo)));
      short_r[lo+2] <= 1'b0;
      wr_reg(A_CLR, 16'h00FF);
      gate_is(3, 8'hFF);
    end
    // Without pairing only the faulty channel drops
    wr_reg(A_PAIR, 16'h0000);
    short_r[1] <= 1'b1;
    gate_is(4, 8'hFD);
    short_r[1] <= 1'b0;
    wr_reg(A_CLR, 16'h00FF);
    gate_is(3, 8'hFF);
    // Paired channels still switch one at a time
    wr_reg(A_PAIR, 16'h000F);
    wr_reg(A_CMD, 16'h00FE);
    gate_is(3, 8'hFE);
    wr_reg(A_CMD, 16'h00FF);
    gate_is(3, 8'hFF);
    // Back-fed channel 3 ignores overload and heat, channel 4 still trips
    rev_r[3] <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    short_r[3] <= 1'b1;
    hot_r[3]   <= 1'b1;
    gate_is(6, 8'hFF);
    rd_reg(A_ERR, rd_v);
    check("err back-fed", rd_v & 16'h0008, 16'h0008);
    short_r[4] <= 1'b1;
    gate_is(4, 8'hAF);
    short_r <= '0;
    hot_r   <= '0;
    rev_r   <= '0;
    wr_reg(A_CLR, 16'h00FF);
    wr_reg(A_PAIR, 16'h0000);
    gate_is(3, 8'hFF);
    // Inrush mode on channel 6 only: it restarts, channel 7 stays latched
    wr_reg(A_BIM, 16'h0040);
    short_r[7:6] <= 2'b11;
    repeat (2) @(posedge clk_sys_i);
    short_r[7:6] <= 2'b00;
    gate_is(2, 8'h3F);
    for (int i = 0; i < 40 && gate_en_o[6] !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    gate_is(1, 8'h7F);
    repeat (250) @(posedge clk_sys_i);
    rd_reg(A_BIM, rd_v);
    check("inrush timeout", rd_v, 16'h0000);
    wr_reg(A_CLR, 16'h00FF);
    // A commanded switch-off drops the inrush bit
    wr_reg(A_BIM, 16'h0020);
    wr_reg(A_CMD, 16'h00DF);
    rd_reg(A_BIM, rd_v);
    check("inrush cleared", rd_v, 16'h0000);
    // Mid-run reset drops every gate and restores the defaults
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    gate_is(2, 8'h00);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    gate_is(1, 8'h00);
    rd_reg(A_CMD, rd_v);
    check("cmd after reset", rd_v, 16'h0000);
    rd_reg(A_TRIM, rd_v);
    check("trim after reset", rd_v, 16'h0008);
    // Read data stand one cycle only, then return to zero
    @(posedge clk_sys_i);
    #1 check("rdata idle", rdata_o, 16'h0000);
    summarize();
  end
endmodule : tb
`default_nettype wire
